// ---- hdl/event_timer_consts.svh ----
// constants for the event timer: reset values, counter landmarks, filter depth
// assumes inclusion by bare name from the design file
`ifndef EVENT_TIMER_CONSTS_SVH
`define EVENT_TIMER_CONSTS_SVH

// ----------------------------------------------------------------------------
// counter landmarks
// ----------------------------------------------------------------------------
`define BOTTOM_VAL 16'h0000
`define MAX_VAL 16'hFFFF

// ----------------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------------
`define CNT_RST 16'h0000
`define CAPTURE_COMPARE_VALUE_RST 16'h0000
`define FILT_SAMPLES 4
`define SS_SYNC_DLY 2

`endif

// ---- hdl/event_timer_pkg.sv ----
// types shared by the event timer: mode encoding, phases, config and access carriers
// assumes nothing of its surroundings
`default_nettype none

package event_timer_pkg;

	// eight operating modes, encoding in declaration order
	typedef enum logic [2:0] {
		MODE_PERIODIC, MODE_TIMEOUT, MODE_CAPTURE_FLAG_EVENT, MODE_FREQ,
		MODE_PULSE_WIDTH, MODE_FREQ_PW, MODE_SINGLE_SHOT, MODE_PWM8
	} timer_mode_e;

	// sequence of the combined frequency and pulse-width measurement
	typedef enum logic [1:0] {FP_IDLE, FP_HIGH, FP_LOW, FP_DONE} fp_phase_e;

	typedef struct packed {
		logic enable;
		timer_mode_e timer_mode_select;
		logic edge_sel;
		logic filter_en;
		logic capture_flag_ei;
		logic async_en;
		logic waveform_output_enable;
		logic output_initial_level;
		logic capture_flag_int_en;
		logic prescale_div2;
	} cfg_s;

	typedef struct packed {
		logic cnt_wr;
		logic [15:0] cnt_wdata;
		logic capture_compare_value_wr;
		logic [15:0] capture_compare_value_wdata;
		logic capture_compare_value_lo_rd;
		logic flag_clr;
	} sw_s;

endpackage

`default_nettype wire

// ---- hdl/event_timer.sv ----
// 16-bit event timer with periodic, time-out, capture, single-shot and 8-bit pwm modes
// assumes config and software strobes are synchronous to clk_sys; event_in is not
//
// How it works
// - periodic mode counts to compare value, flags, then restarts from zero
// - compare lowered below count: counter runs to all-ones and wraps
// - time-out mode starts on selected edge, freezes on the opposite edge
// - time-out mode flags when count meets compare before the stop edge
// - frozen time-out counter restarts on start edge; reads have no side effect
// - capture mode counts freely and copies count on each selected edge
// - reading compare low byte clears the flag in capture modes
// - frequency mode captures count then restarts on each selected edge
// - pulse-width mode restarts on rise, captures and flags on fall
// - combined mode: start on rise, capture on fall, stop and flag on rise
// - single-shot: output low when stopped, high while counting to compare
// - single-shot ignores events during the low hold after stopping
// - synchronous single-shot output rises two cycles after the event
// - single-shot trigger: any edge with edge select set, else rising only
// - asynchronous single-shot sets output at once, counter starts later
// - pwm: low byte is period minus one, high byte is high time
// - output enable drives waveform to pin, otherwise no waveform
// - other modes drive the initial output level
// - noise filter passes input after four equal samples
// - bottom is count zero
// - max is all ones, where the counter wraps
// - interrupt asserted while enabled and flag set
`include "event_timer_consts.svh"
`default_nettype none

module event_timer #(
	parameter int FILT_LEN = `FILT_SAMPLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire event_timer_pkg::cfg_s cfg,
	input wire event_timer_pkg::sw_s sw,
	input wire logic event_in,
	output logic [15:0] count_value,
	output logic [15:0] capture_compare_value,
	output logic capture_flag,
	output logic capture_flag_event,
	output logic irq,
	output logic running,
	output logic wave_pin,
	output logic wave_drive
);

	// ------------------------------------------------------------------------
	// event input: synchroniser, noise filter, edge detect
	// ------------------------------------------------------------------------
	logic [1:0] sync_q;
	logic [FILT_LEN-1:0] samp_q;
	logic filt_q;
	logic lvl_q;

	// first stage is read only by the second stage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync_q <= 2'h0;
			samp_q <= '0;
			filt_q <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			sync_q <= {sync_q[0], event_in};
			samp_q <= {samp_q[FILT_LEN-2:0], sync_q[1]};
			if (!cfg.filter_en)
				filt_q <= sync_q[1];
			else if (&samp_q || ~|samp_q)
				filt_q <= samp_q[0];
			lvl_q <= filt_q;
		end
	end

	wire rise = cfg.capture_flag_ei & filt_q & ~lvl_q;
	wire fall = cfg.capture_flag_ei & ~filt_q & lvl_q;
	wire sel_edge = cfg.edge_sel ? fall : rise;
	wire opp_edge = cfg.edge_sel ? rise : fall;
	wire ss_trig = cfg.edge_sel ? (rise | fall) : rise;

	// ------------------------------------------------------------------------
	// prescaler and mode decode
	// ------------------------------------------------------------------------
	logic pre_q;
	logic en_q;
	logic [15:0] cnt_q, cnt_d, capture_compare_value_q, capture_compare_value_d;
	logic run_q, run_d, wave_q, wave_d, hold_q, hold_d, arm_q, arm_d;
	logic flag_q, ss_dly_q, set;
	event_timer_pkg::fp_phase_e phase_q, phase_d;

	// one counter tick per clk_sys, or every second one when divided
	wire tick = cfg.enable & (~cfg.prescale_div2 | pre_q);
	wire [2:0] mode_bits = cfg.timer_mode_select;
	wire m_single = mode_bits == event_timer_pkg::MODE_SINGLE_SHOT;
	wire m_pwm = mode_bits == event_timer_pkg::MODE_PWM8;
	wire m_capture = mode_bits inside {event_timer_pkg::MODE_CAPTURE_FLAG_EVENT,
		event_timer_pkg::MODE_FREQ, event_timer_pkg::MODE_PULSE_WIDTH,
		event_timer_pkg::MODE_FREQ_PW};
	wire at_top = cnt_q == capture_compare_value_q;
	wire [15:0] cnt_inc = cnt_q + 16'h0001; // wraps past `MAX_VAL
	wire ss_go = cfg.enable & m_single & ss_trig & ~run_q & ~hold_q & ~ss_dly_q;
	wire ss_boot = cfg.enable & ~en_q & m_single & ~at_top; // count at compare stays idle
	// a read that collides with a new capture leaves the flag set
	wire clr = sw.flag_clr | (sw.capture_compare_value_lo_rd & m_capture);
	wire flag_d = set | (flag_q & ~clr);
	wire [7:0] pwm_next = (cnt_q[7:0] == capture_compare_value_q[7:0]) ? 8'h00 : cnt_q[7:0] + 8'h01;

	// ------------------------------------------------------------------------
	// counter and waveform next state
	// ------------------------------------------------------------------------
	always_comb begin
		cnt_d = cnt_q;
		capture_compare_value_d = capture_compare_value_q;
		run_d = run_q;
		wave_d = cfg.output_initial_level;
		hold_d = hold_q;
		arm_d = arm_q;
		phase_d = phase_q;
		set = 1'b0;
		if (!cfg.enable) begin
			run_d = 1'b0;
			hold_d = 1'b0;
			phase_d = event_timer_pkg::FP_IDLE;
			if (m_single || m_pwm)
				wave_d = 1'b0;
		end else begin
			unique case (cfg.timer_mode_select)
				event_timer_pkg::MODE_PERIODIC: begin
					run_d = 1'b1;
					if (tick && at_top) begin
						set = 1'b1;
						cnt_d = `BOTTOM_VAL;
					end else if (tick) begin
						cnt_d = cnt_inc;
					end
				end
				event_timer_pkg::MODE_TIMEOUT: begin
					if (sel_edge && !run_q) begin
						cnt_d = `BOTTOM_VAL;
						run_d = 1'b1;
					end else if (opp_edge && run_q) begin
						run_d = 1'b0;
					end else if (run_q && tick) begin
						set = at_top;
						cnt_d = cnt_inc;
					end
				end
				event_timer_pkg::MODE_CAPTURE_FLAG_EVENT: begin
					run_d = 1'b1;
					if (sel_edge) begin
						capture_compare_value_d = cnt_q;
						set = 1'b1;
					end
					if (tick)
						cnt_d = cnt_inc;
				end
				event_timer_pkg::MODE_FREQ: begin
					run_d = 1'b1;
					if (sel_edge) begin
						capture_compare_value_d = cnt_q;
						cnt_d = `BOTTOM_VAL;
						set = 1'b1;
					end else if (tick) begin
						cnt_d = cnt_inc;
					end
				end
				event_timer_pkg::MODE_PULSE_WIDTH: begin
					run_d = 1'b1;
					if (rise) begin
						cnt_d = `BOTTOM_VAL;
						arm_d = 1'b1;
					end else if (fall && arm_q) begin
						capture_compare_value_d = cnt_q;
						set = 1'b1;
						arm_d = 1'b0;
					end else if (tick) begin
						cnt_d = cnt_inc;
					end
				end
				event_timer_pkg::MODE_FREQ_PW: begin
					unique case (phase_q)
						event_timer_pkg::FP_IDLE: if (rise) begin
							cnt_d = `BOTTOM_VAL;
							run_d = 1'b1;
							phase_d = event_timer_pkg::FP_HIGH;
						end
						event_timer_pkg::FP_HIGH: if (fall) begin
							capture_compare_value_d = cnt_q;
							phase_d = event_timer_pkg::FP_LOW;
						end
						event_timer_pkg::FP_LOW: if (rise) begin
							run_d = 1'b0;
							set = 1'b1;
							phase_d = event_timer_pkg::FP_DONE;
						end
						event_timer_pkg::FP_DONE: if (!flag_q)
							phase_d = event_timer_pkg::FP_IDLE; // count held until read
					endcase
					if (run_q && run_d && tick)
						cnt_d = cnt_inc;
				end
				event_timer_pkg::MODE_SINGLE_SHOT: begin
					wave_d = wave_q;
					if (ss_boot || ss_dly_q) begin
						cnt_d = ss_dly_q ? `BOTTOM_VAL : cnt_q;
						run_d = 1'b1;
						wave_d = 1'b1;
					end else if (run_q && tick && at_top) begin
						run_d = 1'b0;
						wave_d = 1'b0;
						hold_d = 1'b1; // low for at least one tick
						set = 1'b1;
					end else if (run_q && tick) begin
						cnt_d = cnt_inc;
					end else if (hold_q && tick) begin
						hold_d = 1'b0;
					end
					if (ss_go && cfg.async_en)
						wave_d = 1'b1;
				end
				event_timer_pkg::MODE_PWM8: begin
					run_d = 1'b1;
					wave_d = wave_q;
					if (tick) begin
						cnt_d = {8'h00, pwm_next};
						if (pwm_next == capture_compare_value_q[15:8])
							wave_d = 1'b0;
						else if (pwm_next == 8'h00)
							wave_d = 1'b1;
					end
				end
			endcase
		end
		// software writes win over counting and capture
		if (sw.cnt_wr)
			cnt_d = sw.cnt_wdata;
		if (sw.capture_compare_value_wr)
			capture_compare_value_d = sw.capture_compare_value_wdata;
	end

	// ------------------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pre_q <= 1'b0;
			en_q <= 1'b0;
			cnt_q <= `CNT_RST;
			capture_compare_value_q <= `CAPTURE_COMPARE_VALUE_RST;
			run_q <= 1'b0;
			wave_q <= 1'b0;
			hold_q <= 1'b0;
			arm_q <= 1'b0;
			phase_q <= event_timer_pkg::FP_IDLE;
			ss_dly_q <= 1'b0;
		end else begin
			pre_q <= cfg.enable & ~pre_q;
			en_q <= cfg.enable;
			cnt_q <= cnt_d;
			capture_compare_value_q <= capture_compare_value_d;
			run_q <= run_d;
			wave_q <= wave_d;
			hold_q <= hold_d;
			arm_q <= arm_d;
			phase_q <= phase_d;
			ss_dly_q <= ss_go; // one stage plus the launch edge
		end
	end

	// ------------------------------------------------------------------------
	// flag, event, interrupt and pin outputs
	// ------------------------------------------------------------------------
	logic capture_flag_event_q, irq_q, wave_pin_q, wave_drive_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
			capture_flag_event_q <= 1'b0;
			irq_q <= 1'b0;
			wave_pin_q <= 1'b0;
			wave_drive_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
			capture_flag_event_q <= set;
			irq_q <= cfg.capture_flag_int_en & flag_d;
			wave_pin_q <= cfg.waveform_output_enable & wave_d;
			wave_drive_q <= cfg.waveform_output_enable;
		end
	end

	assign count_value = cnt_q;
	assign capture_compare_value = capture_compare_value_q;
	assign capture_flag = flag_q;
	assign capture_flag_event = capture_flag_event_q;
	assign irq = irq_q;
	assign running = run_q;
	assign wave_pin = wave_pin_q;
	assign wave_drive = wave_drive_q;

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	irq_level_a: assert property (irq_q |-> flag_q && $past(cfg.capture_flag_int_en))
		else $error("interrupt without flag or enable");
	periodic_wrap_a: assert property (cfg.enable && !m_single && !m_pwm && !sw.cnt_wr
		&& mode_bits == event_timer_pkg::MODE_PERIODIC && tick && at_top
		|=> cnt_q == `BOTTOM_VAL && flag_q && capture_flag_event_q)
		else $error("periodic match did not restart and flag");
	capture_copy_a: assert property (cfg.enable && !sw.capture_compare_value_wr
		&& mode_bits == event_timer_pkg::MODE_CAPTURE_FLAG_EVENT && sel_edge
		|=> capture_compare_value_q == $past(cnt_q) && flag_q)
		else $error("capture did not copy count");
	read_clear_a: assert property (m_capture && sw.capture_compare_value_lo_rd && !set |=> !flag_q)
		else $error("low byte read did not clear flag");
	freq_restart_a: assert property (cfg.enable && !sw.cnt_wr
		&& mode_bits == event_timer_pkg::MODE_FREQ && sel_edge |=> cnt_q == `BOTTOM_VAL)
		else $error("frequency capture did not restart");
	shot_delay_a: assert property (ss_go && !cfg.async_en |-> ##2 run_q && wave_q)
		else $error("single shot output late");
	shot_async_a: assert property (ss_go && cfg.async_en |=> wave_q ##1 run_q)
		else $error("asynchronous single shot not set at once");
	shot_ignore_a: assert property (m_single && hold_q && ss_trig && cfg.enable
		|=> !run_q && !ss_dly_q)
		else $error("event retriggered during low hold");
	pwm_period_a: assert property (cfg.enable && m_pwm && tick && !sw.cnt_wr && !sw.capture_compare_value_wr
		&& cnt_q[7:0] == capture_compare_value_q[7:0] |=> cnt_q == `BOTTOM_VAL && wave_q == (capture_compare_value_q[15:8] != 8'h00))
		else $error("pwm period end wrong");
	pin_enable_a: assert property (!$past(cfg.waveform_output_enable) |-> !wave_pin_q && !wave_drive_q)
		else $error("waveform on pin while disabled");

endmodule // event_timer

`default_nettype wire

// ---- bench/event_source.sv ----
// event channel model: one level line toward the timer
// assumes the bench calls hold from one process at a time
`default_nettype none

module event_source (
	input wire logic clk_sys,
	output logic event_in
);
	timeunit 1ns;
	timeprecision 100ps;

	initial event_in = 1'b0;

	// set a level just after an edge and keep it for some cycles; callers keep
	// edges two or more cycles apart so the edge detector never misses one
	task automatic hold(input logic lvl, input int cycles);
		@(posedge clk_sys);
		event_in <= lvl;
		repeat (cycles - 1) @(posedge clk_sys);
	endtask
endmodule // event_source

`default_nettype wire

// ---- bench/event_timer_capture_modes_test.sv ----
// bench for the event timer: one task per scenario, closing verdict
// assumes event_source as channel model and software strobes from the bench
`default_nettype none

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module event_timer_capture_modes_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	event_timer_pkg::cfg_s cfg = '0;
	event_timer_pkg::sw_s sw = '0;
	wire logic ev;
	wire logic [15:0] cnt, ccv;
	wire logic flag, cevt, irq, run, wave, drv;
	int num_errors = 0;
	int compares = 0;
	int n, c;

	// ------------------------------------------------------------
	// clock, parts
	// ------------------------------------------------------------
	always #5 clk_sys = ~clk_sys;

	event_source ev_u (.clk_sys(clk_sys), .event_in(ev));

	event_timer dut_u (.clk_sys(clk_sys), .rst(rst), .cfg(cfg), .sw(sw), .event_in(ev),
		.count_value(cnt), .capture_compare_value(ccv), .capture_flag(flag),
		.capture_flag_event(cevt), .irq(irq), .running(run), .wave_pin(wave), .wave_drive(drv));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tick(input int k = 1);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	// one software strobe: 0 count write, 1 compare write, 2 low read, 3 flag clear
	task automatic sw_op(input int k, input logic [15:0] v);
		event_timer_pkg::sw_s s;
		s = '0;
		s.cnt_wr = (k == 0);
		s.cnt_wdata = v;
		s.capture_compare_value_wr = (k == 1);
		s.capture_compare_value_wdata = v;
		s.capture_compare_value_lo_rd = (k == 2);
		s.flag_clr = (k == 3);
		@(posedge clk_sys);
		sw <= s;
		@(posedge clk_sys);
		sw <= '0;
	endtask

	// mode chosen while disabled, flags cleared after enabling
	task automatic setup(input event_timer_pkg::timer_mode_e m, input logic [15:0] cp, c0);
		event_timer_pkg::cfg_s g;
		g = '0;
		g.timer_mode_select = m;
		g.capture_flag_ei = 1'b1;
		g.capture_flag_int_en = 1'b1;
		g.waveform_output_enable = 1'b1;
		ev_u.hold(1'b0, 4);
		cfg <= g;
		sw_op(1, cp);
		sw_op(0, c0);
		@(posedge clk_sys);
		cfg.enable <= 1'b1;
		sw_op(3, 16'h0000);
		tick();
	endtask

	task automatic wait_evt(input int lim, output int k);
		k = 0;
		do begin
			tick();
			k++;
		end while (cevt !== 1'b1 && k < lim);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_periodic();
		setup(event_timer_pkg::MODE_PERIODIC, 16'h0005, 16'h0000);
		wait_evt(20, n);
		`CHK("bottom", 16'h0000, cnt)
		`CHK("irq", 1'b1, irq)
		wait_evt(20, n);
		`CHK("period", 6, n)
		sw_op(0, 16'hFFFC);
		tick(4);
		`CHK("wrap", 16'h0000, cnt)
		sw_op(3, 16'h0000);
		tick();
		`CHK("irq off", 1'b0, irq)
		@(posedge clk_sys);
		cfg.output_initial_level <= 1'b1;
		tick(2);
		`CHK("init lvl", 2'b11, {drv, wave})
		@(posedge clk_sys);
		cfg.waveform_output_enable <= 1'b0;
		tick(2);
		`CHK("no wave", 2'b00, {drv, wave})
		// halved counter clock doubles the period
		@(posedge clk_sys);
		cfg.prescale_div2 <= 1'b1;
		wait_evt(40, n);
		wait_evt(40, n);
		`CHK("div2", 12, n)
		$display("periodic done");
	endtask

	task automatic t_capture();
		setup(event_timer_pkg::MODE_CAPTURE_FLAG_EVENT, 16'h0000, 16'h0000);
		ev_u.hold(1'b1, 4);
		wait_evt(20, n);
		`CHK("capture", 16'h0001, cnt - ccv)
		sw_op(2, 16'h0000);
		tick();
		`CHK("lo read", 1'b0, flag)
		@(posedge clk_sys);
		cfg.filter_en <= 1'b1;
		ev_u.hold(1'b0, 8);
		ev_u.hold(1'b1, 2);
		ev_u.hold(1'b0, 10);
		`CHK("glitch", 1'b0, flag)
		ev_u.hold(1'b1, 2);
		wait_evt(20, n);
		`CHK("filtered", 1'b1, flag)
		$display("capture done");
	endtask

	task automatic t_measure();
		setup(event_timer_pkg::MODE_FREQ, 16'h0000, 16'h0000);
		repeat (3) begin
			ev_u.hold(1'b1, 2);
			ev_u.hold(1'b0, 8);
		end
		`CHK("freq", 16'h0009, ccv)
		setup(event_timer_pkg::MODE_PULSE_WIDTH, 16'h0000, 16'h0000);
		ev_u.hold(1'b1, 7);
		ev_u.hold(1'b0, 2);
		tick(6);
		`CHK("width", 16'h0006, ccv)
		setup(event_timer_pkg::MODE_FREQ_PW, 16'h0000, 16'h0000);
		ev_u.hold(1'b1, 5);
		ev_u.hold(1'b0, 6);
		ev_u.hold(1'b1, 2);
		ev_u.hold(1'b0, 2);
		tick(6);
		c = cnt;
		`CHK("fpw cap", 16'h0004, ccv)
		`CHK("fpw flag", 1'b1, flag)
		tick(3);
		`CHK("fpw stop", c[15:0], cnt)
		$display("measure done");
	endtask

	task automatic t_timeout();
		setup(event_timer_pkg::MODE_TIMEOUT, 16'h0008, 16'h0000);
		tick(3);
		`CHK("idle", 16'h0000, cnt)
		ev_u.hold(1'b1, 3);
		wait_evt(20, n);
		`CHK("expired", 1'b1, n < 20)
		ev_u.hold(1'b0, 6);
		c = cnt;
		tick(3);
		`CHK("frozen", c[15:0], cnt)
		ev_u.hold(1'b1, 6);
		tick();
		`CHK("restart", 1'b1, cnt != c[15:0])
		$display("timeout done");
	endtask

	task automatic t_shot();
		setup(event_timer_pkg::MODE_SINGLE_SHOT, 16'h0006, 16'h0006);
		tick(3);
		`CHK("idle low", 2'b00, {run, wave})
		`CHK("no boot", 1'b0, flag)
		ev_u.hold(1'b1, 3);
		for (n = 0; n < 20 && wave !== 1'b1; n++) tick();
		`CHK("sync run", 1'b1, run)
		for (n = 0; n < 20 && wave === 1'b1; n++) tick();
		`CHK("width", 7, n)
		`CHK("drive", 1'b1, drv)
		ev_u.hold(1'b0, 10);
		`CHK("fall ign", 1'b0, run)
		// second rise lands in the cycle the stopped counter holds low
		ev_u.hold(1'b1, 3);
		ev_u.hold(1'b0, 6);
		ev_u.hold(1'b1, 4);
		tick(2);
		`CHK("retrig ign", 1'b0, run)
		ev_u.hold(1'b0, 3);
		cfg.async_en <= 1'b1;
		ev_u.hold(1'b1, 1);
		for (n = 0; n < 20 && wave !== 1'b1; n++) tick();
		`CHK("async", 1'b0, run)
		// with edge select set a falling edge starts the shot as well
		ev_u.hold(1'b1, 12);
		cfg.edge_sel <= 1'b1;
		ev_u.hold(1'b0, 8);
		`CHK("any edge", 1'b1, run)
		$display("single shot done");
	endtask

	task automatic t_pwm();
		setup(event_timer_pkg::MODE_PWM8, 16'h0309, 16'h0000);
		for (n = 0; n < 30 && wave !== 1'b0; n++) tick();
		for (n = 0; n < 30 && wave !== 1'b1; n++) tick();
		c = 0;
		repeat (10) begin
			c += wave;
			tick();
		end
		`CHK("duty", 3, c)
		`CHK("period", 1'b1, wave)
		$display("pwm done");
	endtask

	// ------------------------------------------------------------
	// run
	// ------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// reset for four cycles, then every scenario in turn
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		tick();
		`CHK("reset", 38'h0, {cnt, ccv, flag, cevt, irq, run, wave, drv})
		t_periodic();
		t_capture();
		t_measure();
		t_timeout();
		t_shot();
		t_pwm();
		close_out();
	end

	// scenarios need well under 2000 cycles
	initial begin
		#200000;
		num_errors++;
		close_out();
	end
endmodule // event_timer_capture_modes_test

`default_nettype wire
